/* src/bbtm_ctrl.sv */
// Write-only control registers of the radio baseband tone and modem block.
// Assumes writes arrive already decoded from the serial control port,
// and mode-control levels come from logic on the same clock.
// Function
// - Turn-off tone replaces digital code on transmit.
// - Turn-off detect needs selection and tone receive.
// - Maintenance tone needs extended transmit and selection.
// - Maintenance decoder needs extended and tone receive.
// - Clone mode reports any detected tone number.
// - Filter bits pick none, narrow, wide filtering.
// - Bit ten enables emphasis independently.
// - Bit thirteen enables compress and expand.
// - Bit fourteen enables frequency inversion scrambling.
// - Five-bit code selects transmitted in-band tone.
// - Raw receive hunts sync, delivers 16-bit words.
// - Packet receive waits full head, then decodes.
// - Raw transmit sends host words; host formats.
// - Packet transmit sends sync, head, then data.
// - Last-data bit lets packet transmitter stop modulating.
// - Bits seven to five give message type.
// - Seed bits choose standard, one, two, none.
// - Receiver descrambles using received seed selection.
// - Special tone bits select none, turnoff, maintenance, clone.
`timescale 1ns/10ps
module bbtm_ctrl #(
	parameter logic [15:0] SYNC_WORD = 16'h3b28, // Frame sync pattern
	parameter logic [15:0] SEED_ONE = 16'h1234, // Programmed seed one
	parameter logic [15:0] SEED_TWO = 16'h5678 // Programmed seed two
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_addr_in,
	input wire logic [15:0] wr_data_in,
	input wire logic sq_code_tx_in,
	input wire logic tone_rx_en_in,
	input wire logic ext_sq_tx_in,
	input wire logic ext_sq_rx_in,
	input wire logic voice_on_in,
	input wire logic inband_tx_en_in,
	input wire logic modem_tx_in,
	input wire logic modem_rx_in,
	input wire logic clone_valid_in,
	input wire logic [5:0] clone_num_in,
	input wire logic tx_ready_in,
	input wire logic rx_valid_in,
	input wire logic [15:0] rx_word_in,
	output logic txd_ready_out,
	output logic tx_turnoff_tone_out,
	output logic rx_turnoff_det_out,
	output logic tx_maint_tone_out,
	output logic rx_maint_det_out,
	output logic clone_en_out,
	output logic [5:0] tone_status_out,
	output logic [1:0] filter_mode_out,
	output logic emphasis_out,
	output logic compand_out,
	output logic scramble_out,
	output logic [4:0] inband_code_out,
	output logic inband_on_out,
	output logic [15:0] prog_word_out,
	output logic prog_strobe_out,
	output logic [2:0] msg_type_out,
	output logic [15:0] tx_word_out,
	output logic tx_valid_out,
	output logic [15:0] rx_word_out,
	output logic rx_valid_out,
	output logic frame_found_out,
	output logic rx_user_bit_out,
	output logic [1:0] rx_seed_sel_out
);
	// All state of the block in one word
	typedef struct packed {
		logic [15:0] audio; // Audio and address control
		logic [15:0] inband; // In-band tone select
		logic [15:0] modem; // Modem control
		logic [15:0] prog; // Programming word
		logic prog_stb; // Programming word written
		logic [15:0] buf0; // Oldest buffered transmit word
		logic [15:0] buf1; // Newer buffered transmit word
		logic [1:0] cnt; // Buffered word count
		logic voice_d; // Voice mode seen last cycle
		logic mtx_d; // Modem transmit seen last cycle
		logic mrx_d; // Modem receive seen last cycle
		logic [1:0] filt; // Latched filter mode
		logic emph; // Latched emphasis
		logic comp; // Latched compandor
		logic scr; // Latched voice scrambler
		logic raw; // Latched raw mode
		logic [7:0] ctrl; // Latched control byte
		bbtm_pkg::bbtm_tx_t tst; // Transmit sequencer
		bbtm_pkg::bbtm_rx_t rst; // Receive sequencer
		logic [15:0] tword; // Word to modulator
		logic tvalid; // Word to modulator valid
		logic [15:0] rword; // Word to host
		logic rvalid; // Word to host valid
		logic found; // Frame found pulse
		logic [1:0] rseed; // Received seed selection
		logic ruser; // Received user bit
		logic to_tx; // Turn-off tone transmit
		logic to_rx; // Turn-off tone detect
		logic mt_tx; // Maintenance tone transmit
		logic mt_rx; // Maintenance decoder on
		logic clone; // Clone mode on
		logic [5:0] tstat; // Tone status
		logic inb_on; // In-band tone on
		logic rdy; // Buffer has room, kept as a flop so the output is registered
	} bbtm_state_t;

	bbtm_state_t r;
	bbtm_state_t n;
	logic [1:0] spc; // Special tone selection
	logic load; // Modulator takes a new word
	logic pop; // Buffer drains one word
	logic [15:0] wd; // Next word to modulator

	// Seed value for a selection code
	function automatic logic [15:0] seed_of(input logic [1:0] sel);
		case (sel)
			2'h0: seed_of = bbtm_pkg::SEED_STD;
			2'h1: seed_of = SEED_ONE;
			2'h2: seed_of = SEED_TWO;
			default: seed_of = bbtm_pkg::SEED_NONE;
		endcase
	endfunction

	// Next state of everything
	always_comb begin
		n = r;
		spc = r.audio[bbtm_pkg::SPC_LSB +: 2];
		load = !r.tvalid || tx_ready_in;
		pop = 1'b0;
		wd = r.buf0;
		n.prog_stb = 1'b0;
		n.found = 1'b0;
		n.rvalid = 1'b0;
		n.voice_d = voice_on_in;
		n.mtx_d = modem_tx_in;
		n.mrx_d = modem_rx_in;
		n.to_tx = sq_code_tx_in && (spc == bbtm_pkg::SPC_TURNOFF);
		n.to_rx = tone_rx_en_in && (spc == bbtm_pkg::SPC_TURNOFF);
		n.mt_tx = ext_sq_tx_in && (spc == bbtm_pkg::SPC_MAINT);
		n.mt_rx = ext_sq_rx_in && tone_rx_en_in;
		n.clone = tone_rx_en_in && (spc == bbtm_pkg::SPC_CLONE);
		if (r.clone && clone_valid_in) begin
			n.tstat = clone_num_in;
		end
		n.inb_on = inband_tx_en_in;
		// Voice settings are only taken when voice mode starts
		if (voice_on_in && !r.voice_d) begin
			n.filt = r.audio[bbtm_pkg::FILT_LSB +: 2];
			if (r.audio[bbtm_pkg::FILT_LSB +: 2] == bbtm_pkg::FILT_RSVD) begin
				n.filt = bbtm_pkg::FILT_NONE;
			end
			n.emph = r.audio[bbtm_pkg::EMPH_BIT];
			n.comp = r.audio[bbtm_pkg::COMP_BIT];
			n.scr = r.audio[bbtm_pkg::SCR_BIT];
		end
		// Raw bit and control byte latched at start; the last-data bit is still read live from the register
		if ((modem_tx_in && !r.mtx_d) || (modem_rx_in && !r.mrx_d)) begin
			n.raw = r.modem[bbtm_pkg::RAW_BIT];
			n.ctrl = r.modem[7:0];
		end
		if (load) begin
			n.tvalid = 1'b0;
		end
		// Transmit sequencer
		case (r.tst)
			bbtm_pkg::TX_IDLE: begin
				if (modem_tx_in && !r.mtx_d) begin
					n.tst = r.modem[bbtm_pkg::RAW_BIT] ? bbtm_pkg::TX_DATA : bbtm_pkg::TX_SYNC;
				end
			end
			bbtm_pkg::TX_SYNC: begin
				if (load) begin
					n.tword = SYNC_WORD;
					n.tvalid = 1'b1;
					n.tst = bbtm_pkg::TX_HEAD;
				end
			end
			bbtm_pkg::TX_HEAD: begin
				if (load) begin
					n.tword = {8'h00, r.ctrl};
					n.tvalid = 1'b1;
					n.tst = bbtm_pkg::TX_HDAT;
				end
			end
			bbtm_pkg::TX_HDAT: begin
				if (load && r.cnt != 2'h0) begin
					n.tword = r.buf0;
					n.tvalid = 1'b1;
					pop = 1'b1;
					if (r.ctrl[bbtm_pkg::TYPE_LSB +: 3] == bbtm_pkg::TYPE_HEAD_ONLY) begin
						n.tst = bbtm_pkg::TX_DONE;
					end else begin
						n.tst = bbtm_pkg::TX_DATA;
					end
				end
			end
			bbtm_pkg::TX_DATA: begin
				if (load && r.cnt != 2'h0) begin
					wd = r.raw ? r.buf0 : (r.buf0 ^ seed_of(r.ctrl[bbtm_pkg::SEED_LSB +: 2]));
					n.tword = wd;
					n.tvalid = 1'b1;
					pop = 1'b1;
				end else if (load && !r.raw && r.modem[bbtm_pkg::LAST_BIT]) begin
					n.tst = bbtm_pkg::TX_DONE;
				end
			end
			bbtm_pkg::TX_DONE: begin
				n.tst = bbtm_pkg::TX_DONE;
			end
			default: begin
				n.tst = bbtm_pkg::TX_IDLE;
			end
		endcase
		if (!modem_tx_in) begin
			n.tst = bbtm_pkg::TX_IDLE;
			n.tvalid = 1'b0;
		end
		// Buffer drain, then fill; a full buffer refuses the write
		if (pop) begin
			n.buf0 = r.buf1;
			n.cnt = r.cnt - 2'h1;
		end
		// Register writes
		if (wr_en_in) begin
			case (wr_addr_in)
				bbtm_pkg::ADDR_AUDIO: n.audio = wr_data_in;
				bbtm_pkg::ADDR_INBAND: n.inband = wr_data_in;
				bbtm_pkg::ADDR_MODEM: n.modem = wr_data_in;
				bbtm_pkg::ADDR_PROG: begin
					n.prog = wr_data_in;
					n.prog_stb = 1'b1;
				end
				bbtm_pkg::ADDR_TXDATA: begin
					if (n.cnt == 2'h0) begin
						n.buf0 = wr_data_in;
						n.cnt = 2'h1;
					end else if (r.cnt != bbtm_pkg::BUF_DEPTH || pop) begin
						n.buf1 = wr_data_in;
						n.cnt = bbtm_pkg::BUF_DEPTH;
					end
				end
				default: n.prog_stb = 1'b0;
			endcase
		end
		// Room flag follows the count the buffer will hold next
		n.rdy = (n.cnt != bbtm_pkg::BUF_DEPTH);
		// Receive sequencer
		if (rx_valid_in) begin
			case (r.rst)
				bbtm_pkg::RX_HUNT: begin
					if (rx_word_in == SYNC_WORD) begin
						n.found = r.raw;
						n.rst = r.raw ? bbtm_pkg::RX_DATA : bbtm_pkg::RX_HEAD;
					end
				end
				bbtm_pkg::RX_HEAD: begin
					n.rseed = rx_word_in[bbtm_pkg::SEED_LSB +: 2];
					n.ruser = rx_word_in[bbtm_pkg::USER_BIT];
					n.rst = bbtm_pkg::RX_HDAT;
				end
				bbtm_pkg::RX_HDAT: begin
					n.rword = rx_word_in;
					n.rvalid = 1'b1;
					n.found = 1'b1;
					n.rst = bbtm_pkg::RX_DATA;
				end
				bbtm_pkg::RX_DATA: begin
					n.rword = r.raw ? rx_word_in : (rx_word_in ^ seed_of(r.rseed));
					n.rvalid = 1'b1;
				end
				default: n.rst = bbtm_pkg::RX_HUNT;
			endcase
		end
		if (!modem_rx_in) begin
			n.rst = bbtm_pkg::RX_HUNT;
		end
	end

	// State register; clock enable freezes everything
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			r <= '0;
			// Empty buffer has room
			r.rdy <= 1'b1;
		end else if (ce_in) begin
			r <= n;
		end
	end

	// Outputs straight from state
	assign txd_ready_out = r.rdy;
	assign tx_turnoff_tone_out = r.to_tx;
	assign rx_turnoff_det_out = r.to_rx;
	assign tx_maint_tone_out = r.mt_tx;
	assign rx_maint_det_out = r.mt_rx;
	assign clone_en_out = r.clone;
	assign tone_status_out = r.tstat;
	assign filter_mode_out = r.filt;
	assign emphasis_out = r.emph;
	assign compand_out = r.comp;
	assign scramble_out = r.scr;
	assign inband_code_out = r.inband[bbtm_pkg::TONE_LSB +: 5];
	assign inband_on_out = r.inb_on;
	assign prog_word_out = r.prog;
	assign prog_strobe_out = r.prog_stb;
	assign msg_type_out = r.modem[bbtm_pkg::TYPE_LSB +: 3];
	assign tx_word_out = r.tword;
	assign tx_valid_out = r.tvalid;
	assign rx_word_out = r.rword;
	assign rx_valid_out = r.rvalid;
	assign frame_found_out = r.found;
	assign rx_user_bit_out = r.ruser;
	assign rx_seed_sel_out = r.rseed;

	a_turnoff_tx: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && sq_code_tx_in && spc == bbtm_pkg::SPC_TURNOFF |=> tx_turnoff_tone_out)
		else $error("turn-off tone not sent");
	a_turnoff_rx: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		$rose(rx_turnoff_det_out) |-> $past(tone_rx_en_in) && $past(spc) == 2'h1)
		else $error("turn-off detect without cause");
	a_maint_tx: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in |=> tx_maint_tone_out == ($past(ext_sq_tx_in) && $past(spc) == 2'h2))
		else $error("maintenance tone wrong");
	a_maint_rx: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && ext_sq_rx_in && tone_rx_en_in |=> rx_maint_det_out)
		else $error("maintenance decoder off");
	a_filter_rsvd: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && voice_on_in && !r.voice_d
		&& r.audio[bbtm_pkg::FILT_LSB +: 2] == bbtm_pkg::FILT_RSVD
		|=> filter_mode_out == 2'h0)
		else $error("reserved filter not mapped");
	a_sync_first: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && modem_tx_in && r.tst == bbtm_pkg::TX_SYNC && load
		|=> tx_valid_out && tx_word_out == SYNC_WORD ##1 !$past(ce_in) || !$past(tx_ready_in)
		|| !$past(modem_tx_in) || r.tst == bbtm_pkg::TX_HDAT)
		else $error("sync not first");
	a_raw_deliver: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && r.raw && r.rst == bbtm_pkg::RX_DATA && rx_valid_in && modem_rx_in
		|=> rx_valid_out && rx_word_out == $past(rx_word_in))
		else $error("raw word not delivered");
	a_head_found: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		ce_in && r.rst == bbtm_pkg::RX_HEAD && rx_valid_in && modem_rx_in
		|=> !frame_found_out)
		else $error("frame event before full head");
endmodule

/* pkg/bbtm_pkg.sv */
// Constants and types for the baseband tone and modem control block.
// Assumes a decoded 16-bit serial write port and a single system clock.
package bbtm_pkg;
	// Register addresses on the serial control port
	localparam logic [7:0] ADDR_AUDIO = 8'hc2;
	localparam logic [7:0] ADDR_INBAND = 8'hc3;
	localparam logic [7:0] ADDR_MODEM = 8'hc7;
	localparam logic [7:0] ADDR_PROG = 8'hc8;
	localparam logic [7:0] ADDR_TXDATA = 8'hca;
	// Value of every register after reset
	localparam logic [15:0] REG_RST = 16'h0000;
	// Audio and address control fields
	localparam int SPC_LSB = 8;
	localparam int EMPH_BIT = 10;
	localparam int FILT_LSB = 11;
	localparam int COMP_BIT = 13;
	localparam int SCR_BIT = 14;
	// In-band tone code field
	localparam int TONE_LSB = 11;
	// Modem control fields
	localparam int RAW_BIT = 10;
	localparam int LAST_BIT = 9;
	localparam int TYPE_LSB = 5;
	localparam int USER_BIT = 2;
	localparam int SEED_LSB = 0;
	// Special sub-audio tone codes
	localparam logic [1:0] SPC_TURNOFF = 2'h1;
	localparam logic [1:0] SPC_MAINT = 2'h2;
	localparam logic [1:0] SPC_CLONE = 2'h3;
	// Voice filter codes
	localparam logic [1:0] FILT_NONE = 2'h0;
	localparam logic [1:0] FILT_RSVD = 2'h3;
	// Message type with head only
	localparam logic [2:0] TYPE_HEAD_ONLY = 3'h1;
	// Scrambler seeds with fixed values
	localparam logic [15:0] SEED_STD = 16'hffff;
	localparam logic [15:0] SEED_NONE = 16'h0000;
	// Transmit buffer depth
	localparam logic [1:0] BUF_DEPTH = 2'h2;
	// Transmit sequencer states
	typedef enum logic [2:0] {TX_IDLE, TX_SYNC, TX_HEAD, TX_HDAT, TX_DATA, TX_DONE} bbtm_tx_t;
	// Receive sequencer states
	typedef enum logic [1:0] {RX_HUNT, RX_HEAD, RX_HDAT, RX_DATA} bbtm_rx_t;
endpackage

/* tb/bbtm_sink.sv */
// Modulator model that takes transmit words from the block, stalling on request.
// Assumes the block's clock and reset, and a registered valid from the block.
`timescale 1ns/10ps
module bbtm_sink (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic slow_in,
	input wire logic valid_in,
	input wire logic [15:0] word_in,
	output logic ready_out,
	output logic took_out,
	output logic [15:0] took_word_out
);
	logic [1:0] phase; // Stall pacing counter
	// Slow mode takes one cycle in four, like a modulator busy shifting bits
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end
	assign ready_out = ~slow_in | (phase == 2'h3);
	// Word handed over at the coming edge
	assign took_out = valid_in & ready_out;
	assign took_word_out = word_in;
endmodule

/* tb/bbtm_ctrl_tb.sv */
// Self-checking bench for the tone and modem control block.
// Assumes the package and the modulator model are compiled first.
`timescale 1ns/10ps
module bbtm_ctrl_tb;
	localparam logic [15:0] SYNC = 16'h3b28;
	localparam logic [15:0] S1 = 16'h1234;
	localparam logic [15:0] S2 = 16'h5678;
	logic clk_sys_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, wr_en_in = 1'b0;
	logic sq_code_tx_in = 1'b0, tone_rx_en_in = 1'b0, ext_sq_tx_in = 1'b0, ext_sq_rx_in = 1'b0;
	logic voice_on_in = 1'b0, inband_tx_en_in = 1'b0, modem_tx_in = 1'b0, modem_rx_in = 1'b0;
	logic clone_valid_in = 1'b0, rx_valid_in = 1'b0, slow = 1'b0, took;
	logic [5:0] clone_num_in = 6'h00;
	logic [7:0] wr_addr_in = 8'h00;
	logic [15:0] wr_data_in = 16'h0000, rx_word_in = 16'h0000;
	logic tx_ready_in, txd_ready_out, tx_turnoff_tone_out, rx_turnoff_det_out, tx_maint_tone_out;
	logic rx_maint_det_out, clone_en_out, emphasis_out, compand_out, scramble_out, inband_on_out;
	logic prog_strobe_out, tx_valid_out, rx_valid_out, frame_found_out, rx_user_bit_out;
	logic [5:0] tone_status_out;
	logic [1:0] filter_mode_out, rx_seed_sel_out;
	logic [4:0] inband_code_out;
	logic [2:0] msg_type_out;
	logic [15:0] prog_word_out, tx_word_out, rx_word_out, took_word, v, ctl, seeds[4];
	logic [15:0] txq[$], rxq[$]; // Expected words, oldest first
	int mismatches = 0, checks = 0, founds = 0, strobes = 0, k, s;
	// Free-running system clock
	always #5 clk_sys_in = ~clk_sys_in;
	bbtm_ctrl #(.SYNC_WORD(SYNC), .SEED_ONE(S1), .SEED_TWO(S2)) DUT (.clk_sys_in, .rst_in,
		.ce_in, .wr_en_in, .wr_addr_in, .wr_data_in, .sq_code_tx_in, .tone_rx_en_in,
		.ext_sq_tx_in, .ext_sq_rx_in, .voice_on_in, .inband_tx_en_in, .modem_tx_in,
		.modem_rx_in, .clone_valid_in, .clone_num_in, .tx_ready_in, .rx_valid_in, .rx_word_in,
		.txd_ready_out, .tx_turnoff_tone_out, .rx_turnoff_det_out, .tx_maint_tone_out,
		.rx_maint_det_out, .clone_en_out, .tone_status_out, .filter_mode_out, .emphasis_out,
		.compand_out, .scramble_out, .inband_code_out, .inband_on_out, .prog_word_out,
		.prog_strobe_out, .msg_type_out, .tx_word_out, .tx_valid_out, .rx_word_out,
		.rx_valid_out, .frame_found_out, .rx_user_bit_out, .rx_seed_sel_out);
	bbtm_sink SINK (.clk_in(clk_sys_in), .rst_in, .slow_in(slow), .valid_in(tx_valid_out),
		.word_in(tx_word_out), .ready_out(tx_ready_in), .took_out(took), .took_word_out(took_word));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Move to just after a rising edge, where all drives change
	task automatic step(int n = 1);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	// One write, then an idle edge so the strobe never toggles twice at once
	task automatic wr(logic [7:0] a, logic [15:0] d);
		wr_en_in = 1'b1;
		wr_addr_in = a;
		wr_data_in = d;
		step();
		wr_en_in = 1'b0;
		step();
	endtask
	// Buffer write that waits for room, bounded
	task automatic wr_buf(logic [15:0] d);
		for (k = 0; k < 300 && txd_ready_out !== 1'b1; k++) step();
		if (k == 300) begin
			mismatches++;
			wrap_up();
		end
		wr(bbtm_pkg::ADDR_TXDATA, d);
	endtask
	task automatic rxw(logic [15:0] w);
		rx_valid_in = 1'b1;
		rx_word_in = w;
		step();
		rx_valid_in = 1'b0;
		step();
	endtask
	// Scoreboard: settled outputs are taken at the falling edge
	always @(negedge clk_sys_in) begin
		if (took === 1'b1) chk("tx word", (txq.size() > 0) ? txq.pop_front() : ~took_word, took_word);
		if (rx_valid_out === 1'b1) chk("rx word", (rxq.size() > 0) ? rxq.pop_front() : ~rx_word_out, rx_word_out);
		if (frame_found_out === 1'b1) founds++;
		if (prog_strobe_out === 1'b1) strobes++;
	end
	initial begin
		s = $urandom(19825);
		seeds = '{bbtm_pkg::SEED_STD, S1, S2, bbtm_pkg::SEED_NONE};
		repeat (12) @(posedge clk_sys_in);
		#1 rst_in = 1'b0;
		step();
		// In-band code; host keeps the low bits zero
		v = 16'($urandom) & 16'hf800;
		wr(bbtm_pkg::ADDR_INBAND, v);
		chk("inband", 16'(v[15:11]), 16'(inband_code_out));
		inband_tx_en_in = 1'b1;
		step(2);
		chk("inband on", 16'h1, 16'(inband_on_out));
		// Frozen clock enable and an unmapped address both leave it alone
		ce_in = 1'b0;
		wr(bbtm_pkg::ADDR_INBAND, ~v);
		ce_in = 1'b1;
		wr(8'h00, ~v);
		chk("inband kept", 16'(v[15:11]), 16'(inband_code_out));
		wr(bbtm_pkg::ADDR_PROG, ~v);
		chk("prog", ~v, prog_word_out);
		chk("strobes", 16'h1, 16'(strobes));
		step(35000);
		for (s = 0; s < 4; s++) begin
			v = {1'b0, 2'($urandom), 2'(s), 1'($urandom), 10'h000};
			wr(bbtm_pkg::ADDR_AUDIO, v);
			voice_on_in = 1'b1;
			step(3);
			chk("filter", (s == 3) ? 16'h0 : 16'(s), 16'(filter_mode_out));
			chk("voice", 16'({v[14:13], v[10]}), 16'({scramble_out, compand_out, emphasis_out}));
			voice_on_in = 1'b0;
			step();
		end
		wr(bbtm_pkg::ADDR_AUDIO, 16'h0100);
		sq_code_tx_in = 1'b1;
		step(2);
		chk("off tx", 16'h1, 16'(tx_turnoff_tone_out));
		chk("off rx", 16'h0, 16'(rx_turnoff_det_out));
		tone_rx_en_in = 1'b1;
		step(2);
		chk("off rx", 16'h1, 16'(rx_turnoff_det_out));
		wr(bbtm_pkg::ADDR_AUDIO, 16'h0200);
		ext_sq_tx_in = 1'b1;
		step(2);
		chk("maint tx", 16'h2, 16'({tx_maint_tone_out, tx_turnoff_tone_out}));
		wr(bbtm_pkg::ADDR_AUDIO, 16'h0000);
		ext_sq_rx_in = 1'b1;
		step(2);
		chk("maint", 16'h1, 16'({tx_maint_tone_out, rx_maint_det_out}));
		wr(bbtm_pkg::ADDR_AUDIO, 16'h0300);
		clone_valid_in = 1'b1;
		clone_num_in = 6'($urandom);
		step();
		clone_valid_in = 1'b0;
		step(2);
		chk("clone", 16'({1'b1, clone_num_in}), 16'({clone_en_out, tone_status_out}));
		{sq_code_tx_in, tone_rx_en_in, ext_sq_tx_in, ext_sq_rx_in} = 4'h0;
		for (s = 0; s < 5; s++) begin
			// Reserved bits zero; last one is raw
			ctl = (s == 4) ? 16'h0400 : {8'h00, 3'h2, 2'h0, 1'b1, 2'(s)};
			wr(bbtm_pkg::ADDR_MODEM, ctl);
			chk("type", (s == 4) ? 16'h0 : 16'h2, 16'(msg_type_out));
			v = 16'($urandom);
			wr_buf(v);
			if (s < 4) txq.push_back(SYNC);
			if (s < 4) txq.push_back({8'h00, ctl[7:0]});
			txq.push_back(v);
			v = 16'($urandom);
			wr_buf(v);
			txq.push_back((s < 4) ? v ^ seeds[s] : v);
			chk("full", 16'h0, 16'(txd_ready_out));
			wr(bbtm_pkg::ADDR_TXDATA, 16'h0f0f);
			slow = s[0];
			modem_tx_in = 1'b1;
			repeat (3) begin
				v = 16'($urandom);
				wr_buf(v);
				txq.push_back((s < 4) ? v ^ seeds[s] : v);
			end
			if (s < 4) wr(bbtm_pkg::ADDR_MODEM, ctl | 16'h0200);
			for (k = 0; k < 300 && txq.size() > 0; k++) step();
			if (k == 300) begin
				mismatches++;
				wrap_up();
			end
			step(10);
			chk("tx left", 16'h0, 16'(txq.size()));
			if (s < 4) chk("stopped", 16'h0, 16'(tx_valid_out));
			modem_tx_in = 1'b0;
			step();
		end
		modem_rx_in = 1'b1;
		step();
		rxw(16'h1111);
		rxw(SYNC);
		repeat (2) begin
			v = 16'($urandom);
			rxq.push_back(v);
			rxw(v);
		end
		chk("found raw", 16'h1, 16'(founds));
		modem_rx_in = 1'b0;
		wr(bbtm_pkg::ADDR_MODEM, 16'h0000);
		modem_rx_in = 1'b1;
		step();
		rxw(SYNC);
		rxw(16'h0045);
		v = 16'($urandom);
		rxq.push_back(v);
		rxw(v);
		v = 16'($urandom);
		rxq.push_back(v);
		rxw(v ^ S1);
		chk("found", 16'h2, 16'(founds));
		chk("rx left", 16'h0, 16'(rxq.size()));
		chk("rx head", 16'h5, 16'({rx_user_bit_out, rx_seed_sel_out}));
		// Head-only type: the second buffered word must never go out
		wr(bbtm_pkg::ADDR_MODEM, 16'h0020);
		chk("type", 16'h1, 16'(msg_type_out));
		v = 16'($urandom);
		wr_buf(v);
		txq.push_back(SYNC);
		txq.push_back(16'h0020);
		txq.push_back(v);
		wr_buf(~v);
		modem_tx_in = 1'b1;
		for (k = 0; k < 300 && txq.size() > 0; k++) step();
		if (k == 300) begin
			mismatches++;
			wrap_up();
		end
		step(10);
		chk("head only", 16'h0, 16'({txq.size() != 0, tx_valid_out}));
		wrap_up();
	end
endmodule
